// >>> gic_top.sv
// grouped interrupt controller: source detection, groups, remap, priority, axi4-lite registers
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module gic_top
    import gic_pkg::*;
#(
    parameter int GRP_W = 8,
    parameter logic [NUM_REMAP-1:0] REMAP_EDGE = 7'h00
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [gic_pkg::NUM_GRP*GRP_W-1:0] grp_src,
    input wire logic [gic_pkg::NUM_REMAP-1:0] remap_src,
    input wire logic [gic_pkg::NUM_EXT-1:0] ext_irq_pin,
    output logic irq,
    output logic cpu_irq,
    output logic [7:0] cpu_vector,
    output logic [gic_pkg::PRIO_W-1:0] cpu_priority
);
    import gic_pkg::*;

    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q, rdata_d;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic do_write, rd_hit, wr_hit, rd_take, status_rd;
    logic [31:0] status_q, status_d, set_vec, mask_q, ext_mode_q, ext_filt_q;
    logic [GRP_W-1:0] grp_en_q [NUM_GRP];
    logic [7:0] remap_vec_q [NUM_REMAP];
    logic [PRIO_W-1:0] prio_q [256];
    logic [1:0] sw_pulse_q;
    logic [NUM_GRP*GRP_W-1:0] grp_prev_q;
    logic [NUM_REMAP-1:0] remap_prev_q;
    logic [NUM_EXT-1:0] ext_s1_q, ext_s2_q, ext_filt_lvl_q, ext_prev_q, ext_det;
    logic irq_q, cpu_irq_q;
    logic [7:0] cpu_vec_q, best_vec;
    logic [PRIO_W-1:0] cpu_prio_q, best_prio;
    logic best_hit;

    // byte-lane merge of a write into a 32-bit register
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // vector number of each status bit
    function automatic logic [7:0] src_vec(input int i, input logic [7:0] rv [NUM_REMAP]);
        logic [7:0] v;
        v = VEC_SW0;
        if (i < NUM_EXT) begin
            v = VEC_EXT_BASE + 8'(i);
        end else if (i < BIT_GRP) begin
            v = VEC_SW0 + 8'(i - BIT_SW0);
        end else if (i < BIT_REMAP) begin
            v = VEC_GRP_BASE + 8'(i - BIT_GRP);
        end else begin
            v = rv[i - BIT_REMAP];
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite write channel: address and data taken in either order
    assign do_write = !awready_q && !wready_q && !bvalid_q;
    assign wr_hit = (awaddr_q >= REG_PRIO) || (awaddr_q <= REG_EXT_FILT) ||
        (awaddr_q >= REG_GRP_EN && awaddr_q < REG_GRP_EN + 12'(4*NUM_GRP)) ||
        (awaddr_q >= REG_REMAP && awaddr_q < REG_REMAP + 12'(4*NUM_REMAP));

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && awready_q) begin
                awready_q <= 1'b0;
                awaddr_q <= {s_axi_awaddr[11:2], 2'b00};
            end
            if (s_axi_wvalid && wready_q) begin
                wready_q <= 1'b0;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // control registers written by software
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= MASK_RESET;
            ext_mode_q <= 32'h0000_0000;
            ext_filt_q <= 32'h0000_0000;
            for (int g = 0; g < NUM_GRP; g++) begin
                grp_en_q[g] <= '0;
            end
            for (int r = 0; r < NUM_REMAP; r++) begin
                remap_vec_q[r] <= VEC_REMAP_LO + 8'(r);
            end
        end else if (do_write) begin
            if (awaddr_q == REG_MASK) begin
                mask_q <= wmerge(mask_q, wdata_q, wstrb_q);
            end
            if (awaddr_q == REG_EXT_MODE) begin
                ext_mode_q <= wmerge(ext_mode_q, wdata_q, wstrb_q);
            end
            if (awaddr_q == REG_EXT_FILT) begin
                ext_filt_q <= wmerge(ext_filt_q, wdata_q, wstrb_q) & 32'h0000_ffff;
            end
            for (int g = 0; g < NUM_GRP; g++) begin
                if (awaddr_q == REG_GRP_EN + 12'(4*g) && wstrb_q[0]) begin
                    grp_en_q[g] <= wdata_q[GRP_W-1:0];
                end
            end
            // out-of-window vectors are ignored, the old routing stays
            for (int r = 0; r < NUM_REMAP; r++) begin
                if (awaddr_q == REG_REMAP + 12'(4*r) && wstrb_q[0] && wdata_q[7:0] >= VEC_REMAP_LO) begin
                    remap_vec_q[r] <= wdata_q[7:0];
                end
            end
        end
    end

    // priority registers, one per vector, no reset so they map to memory
    always_ff @(posedge sys_clk) begin
        if (do_write && awaddr_q >= REG_PRIO && wstrb_q[0]) begin
            prio_q[awaddr_q[9:2]] <= wdata_q[PRIO_W-1:0];
        end
    end

    // software sources pulse once per write of a one
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sw_pulse_q <= 2'b00;
        end else begin
            sw_pulse_q <= (do_write && awaddr_q == REG_SWINT && wstrb_q[0]) ? wdata_q[1:0] : 2'b00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite read channel
    assign rd_take = s_axi_arvalid && arready_q;
    assign status_rd = rd_take && s_axi_araddr[11:2] == REG_STATUS[11:2];

    always_comb begin
        rd_hit = 1'b1;
        rdata_d = 32'h0000_0000;
        if (s_axi_araddr >= REG_PRIO) begin
            rdata_d = 32'(prio_q[s_axi_araddr[9:2]]);
        end else begin
            unique case ({s_axi_araddr[11:2], 2'b00})
                REG_STATUS: rdata_d = status_q;
                REG_MASK: rdata_d = mask_q;
                REG_SWINT: rdata_d = 32'h0000_0000;
                REG_EXT_MODE: rdata_d = ext_mode_q;
                REG_EXT_FILT: rdata_d = ext_filt_q;
                default: begin
                    rd_hit = 1'b0;
                    for (int g = 0; g < NUM_GRP; g++) begin
                        if ({s_axi_araddr[11:2], 2'b00} == REG_GRP_EN + 12'(4*g)) begin
                            rd_hit = 1'b1;
                            rdata_d = 32'(grp_en_q[g]);
                        end
                    end
                    for (int r = 0; r < NUM_REMAP; r++) begin
                        if ({s_axi_araddr[11:2], 2'b00} == REG_REMAP + 12'(4*r)) begin
                            rd_hit = 1'b1;
                            rdata_d = 32'(remap_vec_q[r]);
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else if (rd_take) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rdata_d;
            rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // external pins: two-flop synchroniser, optional filter, mode detection
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_s1_q <= '1;
            ext_s2_q <= '1;
            ext_prev_q <= '1;
        end else begin
            ext_s1_q <= ext_irq_pin;
            ext_s2_q <= ext_s1_q;
            ext_prev_q <= ext_filt_lvl_q;
        end
    end

    for (genvar p = 0; p < NUM_EXT; p++) begin : g_ext
        localparam int CNT_W = $clog2(FILT_CYCLES + 1);
        logic [CNT_W-1:0] cnt_q;
        // a new level is accepted only after it held for the filter time
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                cnt_q <= '0;
                ext_filt_lvl_q[p] <= 1'b1;
            end else if (!ext_filt_q[p] || ext_s2_q[p] == ext_filt_lvl_q[p]) begin
                cnt_q <= '0;
                ext_filt_lvl_q[p] <= ext_filt_q[p] ? ext_filt_lvl_q[p] : ext_s2_q[p];
            end else if (cnt_q == CNT_W'(FILT_CYCLES - 1)) begin
                cnt_q <= '0;
                ext_filt_lvl_q[p] <= ext_s2_q[p];
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
        // detection per selected mode
        always_comb begin
            unique case (gic_ext_mode_t'(ext_mode_q[2*p +: 2]))
                EXT_LOW: ext_det[p] = !ext_filt_lvl_q[p];
                EXT_FALL: ext_det[p] = ext_prev_q[p] && !ext_filt_lvl_q[p];
                EXT_RISE: ext_det[p] = !ext_prev_q[p] && ext_filt_lvl_q[p];
                EXT_BOTH: ext_det[p] = ext_prev_q[p] != ext_filt_lvl_q[p];
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // peripheral sources: previous values for edge detection
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            grp_prev_q <= '0;
            remap_prev_q <= '0;
        end else begin
            grp_prev_q <= grp_src;
            remap_prev_q <= remap_src;
        end
    end

    // event vector: groups merge enabled members, method fixed per group
    always_comb begin
        logic [GRP_W-1:0] cur, prv;
        cur = '0;
        prv = '0;
        set_vec = 32'h0000_0000;
        set_vec[NUM_EXT-1:0] = ext_det;
        set_vec[BIT_SW0 +: 2] = sw_pulse_q;
        for (int g = 0; g < NUM_GRP; g++) begin
            cur = grp_src[g*GRP_W +: GRP_W] & grp_en_q[g];
            prv = grp_prev_q[g*GRP_W +: GRP_W] & grp_en_q[g];
            if (g == GRP_CORE_EDGE || g == GRP_B_EDGE) begin
                set_vec[BIT_GRP + g] = |(cur & ~prv);
            end else begin
                set_vec[BIT_GRP + g] = |cur;
            end
        end
        for (int r = 0; r < NUM_REMAP; r++) begin
            set_vec[BIT_REMAP + r] = REMAP_EDGE[r] ? remap_src[r] && !remap_prev_q[r] : remap_src[r];
        end
    end

    // sticky status: a read clears, a new event in the same cycle wins
    assign status_d = (status_q & ~(status_rd ? 32'hffff_ffff : 32'h0000_0000)) | set_vec;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= 32'h0000_0000;
        end else begin
            status_q <= status_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // highest-priority unmasked pending source toward the cpu
    always_comb begin
        logic [7:0] v;
        v = 8'h00;
        best_hit = 1'b0;
        best_vec = 8'h00;
        best_prio = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            v = src_vec(i, remap_vec_q);
            if (status_q[i] && mask_q[i] && prio_q[v] > best_prio) begin
                best_hit = 1'b1;
                best_vec = v;
                best_prio = prio_q[v];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
            cpu_irq_q <= 1'b0;
            cpu_vec_q <= 8'h00;
            cpu_prio_q <= '0;
        end else begin
            irq_q <= |(status_d & mask_q);
            cpu_irq_q <= best_hit;
            cpu_vec_q <= best_vec;
            cpu_prio_q <= best_prio;
        end
    end

    assign irq = irq_q;
    assign cpu_irq = cpu_irq_q;
    assign cpu_vector = cpu_vec_q;
    assign cpu_priority = cpu_prio_q;
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_sw_pulse_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sw_pulse_q[0] |=> status_q[BIT_SW0]) else $error("software source did not set status");
    a_level_grp_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
        |(grp_src[GRP_B_LEVEL*GRP_W +: GRP_W] & grp_en_q[GRP_B_LEVEL]) |=> status_q[BIT_GRP + GRP_B_LEVEL])
        else $error("level group dropped while member requests");
    a_edge_grp_edge: assert property (@(posedge sys_clk) disable iff (!rst_n)
        set_vec[BIT_GRP + GRP_CORE_EDGE] |-> |(grp_src[GRP_W-1:0] & ~grp_prev_q[GRP_W-1:0]))
        else $error("edge group fired without an edge");
    a_remap_window: assert property (@(posedge sys_clk) disable iff (!rst_n)
        remap_vec_q[0] >= VEC_REMAP_LO) else $error("remap vector out of window");
    a_ext_low_det: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ext_mode_q[7:6] == 2'b00 && !ext_filt_lvl_q[3] |=> status_q[3]) else $error("low level not detected");
    a_filter_glitch: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(ext_filt_q[5]) && $changed(ext_filt_lvl_q[5]) |->
        $past(ext_s2_q[5], 1) == ext_filt_lvl_q[5] && $past(ext_s2_q[5], 2) == ext_filt_lvl_q[5] &&
        $past(ext_s2_q[5], 3) == ext_filt_lvl_q[5] && $past(ext_s2_q[5], 4) == ext_filt_lvl_q[5])
        else $error("filter passed an unheld level");
    a_cpu_prio_match: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cpu_irq_q |-> cpu_prio_q != '0) else $error("cpu request with priority zero");
    a_read_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
        status_rd && set_vec == 32'h0000_0000 |=> status_q == 32'h0000_0000) else $error("read did not clear status");
    a_write_answer: assert property (@(posedge sys_clk) disable iff (!rst_n)
        do_write |=> bvalid_q && !do_write) else $error("write not answered");
endmodule
`default_nettype wire

// >>> gic_pkg.sv
// package: register map, field layout and timing constants of the grouped interrupt controller
`default_nettype none
package gic_pkg;
    // register byte offsets
    localparam logic [11:0] REG_STATUS = 12'h000;
    localparam logic [11:0] REG_MASK = 12'h004;
    localparam logic [11:0] REG_SWINT = 12'h008;
    localparam logic [11:0] REG_EXT_MODE = 12'h00c;
    localparam logic [11:0] REG_EXT_FILT = 12'h010;
    localparam logic [11:0] REG_GRP_EN = 12'h020;
    localparam logic [11:0] REG_REMAP = 12'h040;
    localparam logic [11:0] REG_PRIO = 12'h400;
    // status bit layout
    localparam int NUM_EXT = 16;
    localparam int NUM_GRP = 7;
    localparam int NUM_REMAP = 7;
    localparam int NUM_SRC = 32;
    localparam int BIT_SW0 = 16;
    localparam int BIT_GRP = 18;
    localparam int BIT_REMAP = 25;
    // group indices: core edge, b edge, b level 0..2, a level 0..1
    localparam int GRP_CORE_EDGE = 0;
    localparam int GRP_B_EDGE = 1;
    localparam int GRP_B_LEVEL = 2;
    localparam int GRP_A_LEVEL = 5;
    // fixed vector numbers of the non-remapped sources
    localparam logic [7:0] VEC_SW0 = 8'h1a;
    localparam logic [7:0] VEC_EXT_BASE = 8'h40;
    localparam logic [7:0] VEC_GRP_BASE = 8'h6a;
    // remappable vector window
    localparam logic [7:0] VEC_REMAP_LO = 8'hd0;
    localparam logic [7:0] VEC_REMAP_HI = 8'hff;
    // external pin detection modes
    typedef enum logic [1:0] {EXT_LOW, EXT_FALL, EXT_RISE, EXT_BOTH} gic_ext_mode_t;
    // reset values and bus answers
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // noise filter: time a level must hold, and the cycle count derived at 200 MHz
    localparam int CLK_PERIOD_PS = 5000;
    localparam int FILT_TIME_NS = 20;
    localparam int FILT_CYCLES = (FILT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PRIO_W = 4;
endpackage
`default_nettype wire

// >>> gic_src_model.sv
// model of the peripheral modules and external pins that feed the controller
`timescale 1ns/100ps
`default_nettype none
module gic_src_model (
    output logic [gic_pkg::NUM_GRP*8-1:0] grp_src,
    output logic [gic_pkg::NUM_REMAP-1:0] remap_src,
    output logic [gic_pkg::NUM_EXT-1:0] ext_irq_pin
);
    import gic_pkg::*;
    // requests start low; pins idle high as with a pull-up
    initial begin
        grp_src = '0;
        remap_src = '0;
        ext_irq_pin = '1;
    end
    // set one request line; called just after a rising clock edge
    task automatic drive(input int kind, input int idx, input logic val);
        case (kind)
            1: grp_src[idx] <= val;
            2: remap_src[idx] <= val;
            default: ext_irq_pin[idx] <= val;
        endcase
    endtask
endmodule
`default_nettype wire

// >>> test_grouped_interrupt_controller.sv
// self-checking bench of the grouped interrupt controller
`timescale 1ns/100ps
`default_nettype none
module test_grouped_interrupt_controller;
    import gic_pkg::*;
    typedef struct {int kind; int idx; logic [31:0] st; logic [7:0] v;} gic_row_t;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, d;
    logic awready, wready, bvalid, arready, rvalid, irq, cpu_irq;
    logic [1:0] bresp, rresp, r;
    logic [7:0] vec;
    logic [3:0] prio;
    logic [3:0] expa = 4'hb, expb = 4'hd;
    wire logic [55:0] grp;
    wire logic [6:0] rmp;
    wire logic [15:0] pin;
    int miscompares = 0, checks = 0;
    // one row per tested source, by kind: 0 software, 1 group member, 2 remap, 3 pin pulsed low
    gic_row_t rows [14] = '{
        '{0, 1, 32'h0001_0000, 8'h1a}, '{0, 2, 32'h0002_0000, 8'h1b},
        '{1, 0, 32'h0004_0000, 8'h6a}, '{1, 15, 32'h0008_0000, 8'h6b},
        '{1, 19, 32'h0010_0000, 8'h6c}, '{1, 25, 32'h0020_0000, 8'h6d},
        '{1, 39, 32'h0040_0000, 8'h6e}, '{1, 42, 32'h0080_0000, 8'h6f},
        '{1, 55, 32'h0100_0000, 8'h70}, '{2, 0, 32'h0200_0000, 8'hd0},
        '{2, 6, 32'h8000_0000, 8'hd6}, '{3, 0, 32'h0000_0001, 8'h40},
        '{3, 7, 32'h0000_0080, 8'h47}, '{3, 15, 32'h0000_8000, 8'h4f}};

    ////////////////////////////////////////////////////////////////////////////////
    always #2.5 sys_clk = ~sys_clk;
    gic_src_model i_src (.grp_src(grp), .remap_src(rmp), .ext_irq_pin(pin));
    gic_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .grp_src(grp),
        .remap_src(rmp), .ext_irq_pin(pin), .irq(irq), .cpu_irq(cpu_irq), .cpu_vector(vec),
        .cpu_priority(prio));

    ////////////////////////////////////////////////////////////////////////////////
    // compare and count
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // bus write; the extra edge keeps bready from being set twice in one step
    task automatic wr(input logic [11:0] a, input logic [31:0] dv, output logic [1:0] rs);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= dv;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        rs = bresp;
        bready <= 1'b0;
        if (n >= 50) miscompares++;
        @(posedge sys_clk);
    endtask
    task automatic w(input logic [11:0] a, input logic [31:0] dv);
        logic [1:0] rs;
        wr(a, dv, rs);
    endtask
    // bus read, same framing as the write
    task automatic rd(input logic [11:0] a, output logic [31:0] dv, output logic [1:0] rs);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        dv = rdata;
        rs = rresp;
        rready <= 1'b0;
        if (n >= 50) miscompares++;
        @(posedge sys_clk);
    endtask
    task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] e);
        logic [31:0] dv;
        logic [1:0] rs;
        rd(a, dv, rs);
        check(nm, dv, e);
    endtask
    task automatic print_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog against a hung handshake
    initial begin
        #100000;
        miscompares++;
        print_verdict();
    end
    // main sequence
    initial begin
        cyc(4);
        rst_n <= 1'b1;
        cyc(1);
        for (int v = 0; v < 256; v++) w(REG_PRIO + 12'(4 * v), 32'h1);
        w(REG_EXT_FILT, 32'h0);
        w(REG_EXT_MODE, 32'h5555_5555);
        for (int g = 0; g < NUM_GRP; g++) w(REG_GRP_EN + 12'(4 * g), 32'hff);
        w(REG_MASK, 32'hffff_ffff);
        cyc(10);
        rd(REG_STATUS, d, r);
        foreach (rows[i]) begin
            if (rows[i].kind == 0) w(REG_SWINT, rows[i].idx);
            else begin
                i_src.drive(rows[i].kind, rows[i].idx, rows[i].kind != 3);
                cyc(3);
                i_src.drive(rows[i].kind, rows[i].idx, rows[i].kind == 3);
            end
            cyc(12);
            check("irq", irq, 32'h1);
            check("cpu irq", cpu_irq, 32'h1);
            check("vector", vec, rows[i].v);
            rc("status", REG_STATUS, rows[i].st);
        end
        // two software sources pending: higher priority wins
        w(REG_PRIO + 12'h68, 32'h3);
        w(REG_PRIO + 12'h6c, 32'h7);
        w(REG_SWINT, 32'h3);
        cyc(4);
        check("vector", vec, 32'h1b);
        check("priority", prio, 32'h7);
        rc("status", REG_STATUS, 32'h0003_0000);
        // remap inside the window, below it (ignored) and at its top
        w(REG_REMAP, 32'he0);
        w(REG_REMAP + 12'h4, 32'h10);
        w(REG_REMAP + 12'h8, 32'hff);
        rc("remap", REG_REMAP + 12'h4, 32'hd1);
        rc("remap", REG_REMAP + 12'h8, 32'hff);
        w(REG_PRIO + 12'h380, 32'h9);
        i_src.drive(2, 0, 1'b1);
        cyc(4);
        i_src.drive(2, 0, 1'b0);
        cyc(4);
        check("vector", vec, 32'he0);
        check("priority", prio, 32'h9);
        rc("status", REG_STATUS, 32'h0200_0000);
        // held members: edge group fires once, level group keeps firing until disabled
        i_src.drive(1, 8, 1'b1);
        i_src.drive(1, 16, 1'b1);
        cyc(4);
        rc("status", REG_STATUS, 32'h0018_0000);
        cyc(4);
        rc("status", REG_STATUS, 32'h0010_0000);
        w(REG_GRP_EN + 12'h8, 32'h0);
        rd(REG_STATUS, d, r);
        cyc(4);
        rc("status", REG_STATUS, 32'h0);
        i_src.drive(1, 8, 1'b0);
        i_src.drive(1, 16, 1'b0);
        // every detection mode on pin 3: low phase, then high phase
        for (int md = 0; md < 4; md++) begin
            w(REG_EXT_MODE, 32'h5555_5515 | 32'(md << 6));
            rd(REG_STATUS, d, r);
            i_src.drive(3, 3, 1'b0);
            cyc(10);
            rc("pin low", REG_STATUS, {28'h0, expa[md], 3'h0});
            i_src.drive(3, 3, 1'b1);
            cyc(10);
            rc("pin high", REG_STATUS, {28'h0, expb[md], 3'h0});
        end
        // filter on pin 5: short glitch dropped, long low accepted
        w(REG_EXT_MODE, 32'h5555_5555);
        w(REG_EXT_FILT, 32'h20);
        rd(REG_STATUS, d, r);
        for (int k = 0; k < 2; k++) begin
            i_src.drive(3, 5, 1'b0);
            cyc(k == 0 ? 2 : 10);
            i_src.drive(3, 5, 1'b1);
            cyc(15);
            rc("filter", REG_STATUS, k == 0 ? 32'h0 : 32'h20);
        end
        // mask gates irq; reading status drops it
        w(REG_MASK, 32'h0);
        w(REG_SWINT, 32'h1);
        cyc(4);
        check("irq", irq, 32'h0);
        w(REG_MASK, 32'h0001_0000);
        cyc(3);
        check("irq", irq, 32'h1);
        rc("status", REG_STATUS, 32'h0001_0000);
        cyc(3);
        check("irq", irq, 32'h0);
        // unmapped address
        wr(12'h100, 32'h1, r);
        check("bresp", r, RESP_SLVERR);
        rd(12'h100, d, r);
        check("rresp", r, RESP_SLVERR);
        check("rdata", d, 32'h0);
        // reset in mid-run with a request pending
        w(REG_SWINT, 32'h1);
        rst_n <= 1'b0;
        cyc(4);
        check("irq", irq, 32'h0);
        check("awready", awready, 32'h1);
        rst_n <= 1'b1;
        cyc(1);
        rc("mask", REG_MASK, MASK_RESET);
        rc("status", REG_STATUS, 32'h0);
        rc("remap", REG_REMAP + 12'h8, 32'hd2);
        print_verdict();
    end
endmodule
`default_nettype wire
